//--- trp_cfg_mem.sv
`timescale 1ns/1ns
`default_nettype none
`include "trp_defs.svh"

// ************************************************************
// configuration space storage, registered read data
// ************************************************************
module trp_cfg_mem (
  input wire logic i_clock,
  input wire logic i_we,
  input wire logic [`TRP_ADDR_W-1:0] i_waddr,
  input wire logic [`TRP_DATA_W-1:0] i_wdata,
  input wire logic i_re,
  input wire logic [`TRP_ADDR_W-1:0] i_raddr,
  output logic [`TRP_DATA_W-1:0] o_rdata
);
  // no reset on the array so it maps to block memory
  logic [`TRP_DATA_W-1:0] mem_reg [0:`TRP_SPACE_WORDS-1];

  initial begin
    for (int i = 0; i < `TRP_SPACE_WORDS; i++) begin
      mem_reg[i] = `TRP_WORD_RST;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem_reg[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_re) begin
      o_rdata <= mem_reg[i_raddr];
    end
  end
endmodule // trp_cfg_mem

`default_nettype wire

//--- trp_defs.svh
`ifndef TRP_DEFS_SVH
`define TRP_DEFS_SVH

// address and data widths of the configuration space
`define TRP_ADDR_W 11
`define TRP_DATA_W 32
`define TRP_SPACE_WORDS 2048
// power-up value of every configuration word, not reloaded by i_rst
`define TRP_WORD_RST 32'h00000000
// cycles that wait-request stays high after a read is taken
`define TRP_READ_WAIT 3
// read latency counter width
`define TRP_CNT_W 2
// configuration record field positions
`define TRP_REC_ADDR_HI 26
`define TRP_REC_ADDR_LO 16
`define TRP_REC_MASK_HI 15
`define TRP_REC_MASK_LO 8
`define TRP_REC_VAL_HI 7
`define TRP_REC_VAL_LO 0

`endif

//--- trp_master_model.sv
`timescale 1ns/1ns
`default_nettype none
`include "trp_defs.svh"
// ***
// user reconfiguration master
// ***
module trp_master_model (
  input wire logic i_clock,
  input wire logic i_wait,
  input wire logic i_grant,
  input wire logic [31:0] i_rdata,
  output logic [10:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_wdata,
  output logic o_req
);
  initial {o_address, o_read, o_write, o_wdata, o_req} = '0;
  task automatic acquire();
    o_req = 1'b1;
    for (int n = 0; n < 16 && i_grant !== 1'b1; n++) @(posedge i_clock) #1;
  endtask
  task automatic drop_req();
    o_req = 1'b0;
  endtask
  task automatic xfer(input logic w, input logic [10:0] a, input logic [31:0] d,
    output logic [31:0] q);
    {o_address, o_read, o_write, o_wdata} = {a, !w, w, d};
    do @(posedge i_clock); while (i_wait !== 1'b0);
    q = i_rdata;
    // released lines flip so a stale copy never passes
    #1 {o_address, o_read, o_write, o_wdata} = {~a, 2'b00, ~d};
    @(posedge i_clock) #1;
  endtask
  task automatic rmw(input logic [26:0] r);
    logic [31:0] q;
    logic [7:0] m;
    logic [10:0] a;
    m = r[`TRP_REC_MASK_HI:`TRP_REC_MASK_LO];
    a = r[`TRP_REC_ADDR_HI:`TRP_REC_ADDR_LO];
    xfer(1'b0, a, 32'h0, q);
    xfer(1'b1, a, {q[31:8], (q[7:0] & ~m) | (r[7:0] & m)}, q);
  endtask
endmodule // trp_master_model
`default_nettype wire

//--- trp_pkg.sv
package trp_pkg;
  typedef enum logic [1:0] {
    TRP_IDLE,
    TRP_RWAIT,
    TRP_RDONE
  } trp_state_t;
  typedef enum logic {
    TRP_OWN_USER,
    TRP_OWN_CAL
  } trp_owner_t;
endpackage

//--- trp_port.sv
`timescale 1ns/1ns
`default_nettype none
`include "trp_defs.svh"


// ************************************************************
// one reconfiguration slave per channel or PLL instance
// ************************************************************
// one dedicated slave here
module trp_port (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [`TRP_ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [`TRP_DATA_W-1:0] i_writedata,
  output logic [`TRP_DATA_W-1:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_user_req,
  output logic o_user_grant,
  input wire logic i_cal_req,
  input wire logic [`TRP_ADDR_W-1:0] i_cal_address,
  input wire logic i_cal_read,
  input wire logic i_cal_write,
  input wire logic [`TRP_DATA_W-1:0] i_cal_writedata,
  output logic [`TRP_DATA_W-1:0] o_cal_readdata,
  output logic o_cal_readvalid,
  output logic o_cal_grant
);

  // ************************************************************
  // arbitration of the internal configuration bus
  // ************************************************************
  trp_pkg::trp_owner_t owner_reg;
  logic user_grant_reg;
  logic cal_grant_reg;
  trp_pkg::trp_state_t state_reg;
  logic busy;
  logic wait_reg;

  // owner only changes between transfers, so nothing is cut mid-access;
  // the write ack cycle still belongs to the transfer it closes
  assign busy = (state_reg != trp_pkg::TRP_IDLE) || !wait_reg;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      owner_reg <= trp_pkg::TRP_OWN_CAL;
      user_grant_reg <= 1'b0;
      cal_grant_reg <= 1'b0;
    end else if (!busy) begin
      // limitation: a user that never drops its request starves calibration
      // calibration keeps the bus while it still asks
      if (owner_reg == trp_pkg::TRP_OWN_CAL && cal_grant_reg && i_cal_req) begin
        user_grant_reg <= 1'b0;
      end else if (i_user_req && !(owner_reg == trp_pkg::TRP_OWN_USER && !user_grant_reg
                   && i_cal_req)) begin
        owner_reg <= trp_pkg::TRP_OWN_USER;
        user_grant_reg <= 1'b1;
        cal_grant_reg <= 1'b0;
      end else if (i_cal_req) begin
        owner_reg <= trp_pkg::TRP_OWN_CAL;
        cal_grant_reg <= 1'b1;
        user_grant_reg <= 1'b0;
      end else begin
        user_grant_reg <= 1'b0;
        cal_grant_reg <= 1'b0;
      end
    end
  end

  assign o_user_grant = user_grant_reg;
  assign o_cal_grant = cal_grant_reg;

  // ************************************************************
  // access path into the configuration space
  // ************************************************************
  logic [`TRP_ADDR_W-1:0] acc_addr;
  logic acc_rd;
  logic acc_wr;
  logic [`TRP_DATA_W-1:0] acc_wdata;
  logic [`TRP_DATA_W-1:0] mem_rdata;
  logic [`TRP_CNT_W-1:0] wait_cnt_reg;
  logic [`TRP_DATA_W-1:0] rdata_reg;
  logic [`TRP_DATA_W-1:0] cal_rdata_reg;
  logic cal_rvalid_reg;
  logic src_cal_reg;

  always_comb begin
    acc_addr = i_address;
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    acc_wdata = i_writedata;
    if (state_reg == trp_pkg::TRP_IDLE) begin
      // the edge that closes a write ack is not a new request
      // read wins when both strobes are high
      if (user_grant_reg) begin
        acc_rd = i_read && wait_reg;
        acc_wr = i_write && !i_read && wait_reg;
      end else if (cal_grant_reg) begin
        acc_addr = i_cal_address;
        acc_rd = i_cal_read;
        acc_wr = i_cal_write && !i_cal_read;
        acc_wdata = i_cal_writedata;
      end
    end
  end

  // one space holds PCS, PMA and bridge words
  trp_cfg_mem u_mem (
    .i_clock(i_clock),
    .i_we(acc_wr),
    .i_waddr(acc_addr),
    .i_wdata(acc_wdata),
    .i_re(acc_rd),
    .i_raddr(acc_addr),
    .o_rdata(mem_rdata)
  );

  // ************************************************************
  // read sequencing and wait-request
  // ************************************************************
  // fixed wait then data
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= trp_pkg::TRP_IDLE;
      wait_cnt_reg <= '0;
      src_cal_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        trp_pkg::TRP_IDLE: begin
          if (acc_rd) begin
            state_reg <= trp_pkg::TRP_RWAIT;
            wait_cnt_reg <= '0;
            src_cal_reg <= !user_grant_reg;
          end
        end
        trp_pkg::TRP_RWAIT: begin
          if (wait_cnt_reg == `TRP_CNT_W'(`TRP_READ_WAIT - 2)) begin
            state_reg <= trp_pkg::TRP_RDONE;
          end
          wait_cnt_reg <= wait_cnt_reg + `TRP_CNT_W'(1);
        end
        trp_pkg::TRP_RDONE: begin
          state_reg <= trp_pkg::TRP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rdata_reg <= '0;
      cal_rdata_reg <= '0;
      cal_rvalid_reg <= 1'b0;
    end else begin
      cal_rvalid_reg <= 1'b0;
      // calibration sees its data two cycles after the take, no stall
      if (state_reg == trp_pkg::TRP_RWAIT && wait_cnt_reg == '0 && src_cal_reg) begin
        cal_rdata_reg <= mem_rdata;
        cal_rvalid_reg <= 1'b1;
      end
      // user data moves only with the falling wait-request, never under a stall
      if (state_reg == trp_pkg::TRP_RWAIT && wait_cnt_reg ==
          `TRP_CNT_W'(`TRP_READ_WAIT - 2) && !src_cal_reg) begin
        rdata_reg <= mem_rdata;
      end
    end
  end

  // high by default, so a master with no grant simply waits
  // stall without grant
  // reset leaves wait-request high, nothing pending
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wait_reg <= 1'b1;
    end else if (state_reg == trp_pkg::TRP_RWAIT && wait_cnt_reg ==
                 `TRP_CNT_W'(`TRP_READ_WAIT - 2) && !src_cal_reg) begin
      wait_reg <= 1'b0;
    end else if (state_reg == trp_pkg::TRP_IDLE && user_grant_reg && i_write && !i_read
                 && wait_reg) begin
      // writes stall one cycle: storage takes a word in one cycle
      // write taken at once
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  assign o_waitrequest = wait_reg;
  assign o_readdata = rdata_reg;
  assign o_cal_readdata = cal_rdata_reg;
  assign o_cal_readvalid = cal_rvalid_reg;
endmodule // trp_port

`default_nettype wire

//--- trp_port_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ***
// port timing checker
// ***
module trp_port_chk (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic i_user_req,
  input wire logic o_user_grant,
  input wire logic i_cal_read,
  input wire logic o_cal_readvalid,
  input wire logic o_cal_grant
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  chk_wait_nogrant: assert property (!o_user_grant |-> o_waitrequest)
    else $error("ack without grant");
  chk_read_lat: assert property ($rose(i_read) && o_user_grant |->
    o_waitrequest[*3] ##1 !o_waitrequest) else $error("read latency");
  chk_write_ack: assert property ($rose(i_write) && o_user_grant && !i_read |=>
    !o_waitrequest) else $error("write not acked");
  chk_ack_single: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("ack too long");
  chk_grant_excl: assert property (!(o_user_grant && o_cal_grant))
    else $error("two owners");
  chk_rst_idle: assert property ($fell(i_rst) |-> o_waitrequest && !o_user_grant)
    else $error("not idle after reset");
  chk_cal_valid: assert property ($rose(i_cal_read) && o_cal_grant |->
    ##[1:3] o_cal_readvalid) else $error("cal read lost");
  chk_data_hold: assert property (o_waitrequest |-> $stable(o_readdata))
    else $error("read data moved");
endmodule // trp_port_chk
bind trp_port trp_port_chk chk_u (.i_clock(i_clock), .i_rst(i_rst), .i_read(i_read),
  .i_write(i_write), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .i_user_req(i_user_req), .o_user_grant(o_user_grant), .i_cal_read(i_cal_read),
  .o_cal_readvalid(o_cal_readvalid), .o_cal_grant(o_cal_grant));
`default_nettype wire

//--- trp_port_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module trp_port_tb;
  typedef struct packed {logic [26:0] rec; logic [31:0] exp;} trp_row_t;
  logic i_clock, i_rst, i_read, i_write, i_user_req, i_cal_req, i_cal_read, i_cal_write;
  logic o_waitrequest, o_user_grant, o_cal_readvalid, o_cal_grant;
  logic [10:0] i_address, i_cal_address;
  logic [31:0] i_writedata, i_cal_writedata, o_readdata, o_cal_readdata, q;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  trp_row_t rows [5] = '{'{27'h008ff04, 32'h4}, '{27'h0080f30, 32'h0},
    '{27'h008f0a5, 32'ha0}, '{27'h7ffff81, 32'h12345681}, '{27'h00100ff, 32'h0}};
  trp_port dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_user_req(i_user_req), .o_user_grant(o_user_grant),
    .i_cal_req(i_cal_req), .i_cal_address(i_cal_address), .i_cal_read(i_cal_read),
    .i_cal_write(i_cal_write), .i_cal_writedata(i_cal_writedata),
    .o_cal_readdata(o_cal_readdata), .o_cal_readvalid(o_cal_readvalid),
    .o_cal_grant(o_cal_grant));
  trp_master_model mst_u (.i_clock(i_clock), .i_wait(o_waitrequest), .i_grant(o_user_grant),
    .i_rdata(o_readdata), .o_address(i_address), .o_read(i_read), .o_write(i_write),
    .o_wdata(i_writedata), .o_req(i_user_req));
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  // ***
  // run control
  // ***
  // ceiling far above the hundred or so cycles needed
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic do_reset();
    i_rst = 1'b1;
    repeat (4) @(posedge i_clock);
    #1 `CHK("wait", 1'b1, o_waitrequest)
    `CHK("grant", 1'b0, o_user_grant)
    i_rst = 1'b0;
  endtask
  task automatic cal_op(input logic w, input logic [31:0] d);
    {i_cal_address, i_cal_read, i_cal_write, i_cal_writedata} = {11'h5, !w, w, d};
    @(posedge i_clock) #1;
    {i_cal_read, i_cal_write, i_cal_writedata} = {2'b00, ~d};
    // idle cycle so two calls never retarget one signal at once
    @(posedge i_clock) #1;
  endtask
  // ***
  // scenarios
  // ***
  initial begin
    {i_cal_req, i_cal_read, i_cal_write, i_cal_address, i_cal_writedata} = '0;
    do_reset();
    mst_u.acquire();
    mst_u.xfer(1'b1, 11'h7ff, 32'h12345600, q);
    foreach (rows[k]) begin
      mst_u.rmw(rows[k].rec);
      mst_u.xfer(1'b0, rows[k].rec[26:16], 32'h0, q);
      `CHK("readback", rows[k].exp, q)
    end
    // calibration gets the bus only once the user lets go
    mst_u.drop_req();
    i_cal_req = 1'b1;
    for (int n = 0; n < 8 && o_cal_grant !== 1'b1; n++) @(posedge i_clock) #1;
    `CHK("cal_grant", 1'b1, o_cal_grant)
    cal_op(1'b1, 32'hcafe0005);
    cal_op(1'b0, 32'h0);
    for (int n = 0; n < 4 && o_cal_readvalid !== 1'b1; n++) @(posedge i_clock) #1;
    `CHK("cal_valid", 1'b1, o_cal_readvalid)
    `CHK("cal_rdata", 32'hcafe0005, o_cal_readdata)
    `CHK("user_wait", 1'b1, o_waitrequest)
    i_cal_req = 1'b0;
    mst_u.acquire();
    mst_u.xfer(1'b0, 11'h5, 32'h0, q);
    `CHK("shared", 32'hcafe0005, q)
    do_reset();
    final_report();
  end
endmodule // trp_port_tb
`default_nettype wire
